/* File: design/hdcu_pkg.sv */
// package of constants for the host debug character link
// assumes a 32-bit APB master and one 20 MHz core clock
package hdcu_pkg;
	// register byte addresses
	localparam logic [31:0] DATA_ADDR   = 32'hFF20_1000;
	localparam logic [31:0] CTRL_ADDR   = 32'hFF20_1004;
	localparam logic [31:0] ISTAT_ADDR  = 32'hFF20_1008;
	localparam logic [31:0] IMASK_ADDR  = 32'hFF20_100C;
	// queue geometry
	localparam int          DEPTH       = 64;
	localparam int          PTR_W       = 6;
	localparam logic [6:0]  DEPTH_CNT   = 7'h40;
	localparam logic [6:0]  IRQ_LEVEL   = 7'h07;
	// data register fields
	localparam int          COUNT_LSB   = 16;
	localparam int          RVALID_BIT  = 15;
	// control register fields
	localparam int          RX_IE_BIT   = 0;
	localparam int          TX_IE_BIT   = 1;
	localparam int          RX_PND_BIT  = 8;
	localparam int          TX_PND_BIT  = 9;
	localparam int          HOSTACC_BIT = 10;
	// interrupt status / mask fields
	localparam int          IS_RX_BIT   = 0;
	localparam int          IS_TX_BIT   = 1;
	localparam int          IS_HOST_BIT = 2;
	localparam int          IS_W        = 3;
	// reset values
	localparam logic [1:0]  CTRL_RST    = 2'h0;
	localparam logic [2:0]  IMASK_RST   = 3'h0;
	// link clock period used by the bench, in ns
	localparam int          LINK_PER_NS = 400;
	localparam int          CORE_PER_NS = 50;
	localparam int          LINK_CYC    = LINK_PER_NS / CORE_PER_NS;
endpackage

/* File: design/hdcu_char_link.sv */
// character link between the host debug transport and an APB processor
// assumes APB on core_clk; host link pins are asynchronous, clocked by linkClk
`timescale 1ns/10ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - data register and control register sit at their two fixed word addresses.
// - each byte from the host enters a 64-deep receive queue.
// - data register bits 31-16 show the receive queue fill.
// - a host byte arriving with the receive queue full is thrown away.
// - bit 15 of a data read is one when a character waits.
// - a data read pops the oldest byte and shows the reduced fill.
// - a data read of an empty queue returns valid zero, byte undefined.
// - a write to data bits 7-0 pushes a byte into the transmit queue.
// - a data write never disturbs the receive queue.
// - control register bits 31-16 show free transmit queue entries.
// - a write with the transmit queue full is dropped.
// - control bit 10 goes to one once the host uses the link.
// - writing one to control bit 10 clears it; zero does nothing.
// - enabled interrupts fire when receive fill or transmit space exceeds seven.
// - pending bits show in control; a data read clears the receive one, a data write the transmit one.
module hdcu_char_link
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// host link, all asynchronous to core_clk
	input  wire logic        linkClk,
	input  wire logic        hostRxValid,
	input  wire logic [7:0]  hostRxData,
	output logic             hostRxReady,
	output logic             hostTxValid,
	output logic      [7:0]  hostTxData,
	input  wire logic        hostTxReady,
	// interrupt
	output logic             irq
);

	//////////////////////////////////////////////////////////////////////////
	// state
	logic [7:0]       rxMem [hdcu_pkg::DEPTH];
	logic [7:0]       txMem [hdcu_pkg::DEPTH];
	logic [5:0]       rxWr_q, rxRd_q, txWr_q, txRd_q;
	logic [6:0]       rxCount_q, rxCount_d, txCount_q, txCount_d;
	logic [10:0]      linkMeta_q, linkSync_q;
	logic             linkClkDly_q;
	logic [9:0]       linkPrev_q;
	logic [1:0]       ctrlEn_q;
	logic             rxPend_q, txPend_q, hostAcc_q;
	logic [2:0]       irqStat_q, irqStat_d, irqMask_q;
	logic [31:0]      prdata_q;
	logic             pready_q, pslverr_q, irq_q;
	logic             hostRxReady_q, hostTxValid_q;
	logic [7:0]       hostTxData_q;

	//////////////////////////////////////////////////////////////////////////
	// link input synchroniser, two flops per pin
	always_ff @(posedge core_clk)
	begin
		linkMeta_q   <= {linkClk, hostRxValid, hostRxData, hostTxReady};
		linkSync_q   <= linkMeta_q;
		linkClkDly_q <= linkSync_q[10];
		linkPrev_q   <= linkSync_q[9:0];   // pins as they stood before the edge
	end

	// synchronised link view; at a detected rise the pins are read from the
	// sample before it, since the host moves them just after that same rise
	wire       linkEdge   = linkSync_q[10] & ~linkClkDly_q;
	wire       rxValidS   = linkPrev_q[9];
	wire [7:0] rxDataS    = linkPrev_q[8:1];
	wire       txReadyS   = linkPrev_q[0];

	//////////////////////////////////////////////////////////////////////////
	// apb decode
	wire selData  = (paddr == hdcu_pkg::DATA_ADDR);
	wire selCtrl  = (paddr == hdcu_pkg::CTRL_ADDR);
	wire selStat  = (paddr == hdcu_pkg::ISTAT_ADDR);
	wire selMask  = (paddr == hdcu_pkg::IMASK_ADDR);
	wire mapped   = selData | selCtrl | selStat | selMask;
	wire accFirst = psel & penable & ~pready_q;
	wire accDone  = psel & penable & pready_q;
	wire rdDone   = accDone & ~pwrite & mapped;
	wire wrDone   = accDone & pwrite & mapped;

	//////////////////////////////////////////////////////////////////////////
	// queue traffic
	wire rxEmpty   = (rxCount_q == 7'h00);
	wire rxFull    = (rxCount_q == hdcu_pkg::DEPTH_CNT);
	wire txFull    = (txCount_q == hdcu_pkg::DEPTH_CNT);
	wire rxTake    = linkEdge & rxValidS & hostRxReady_q;
	wire rxPush    = rxTake & ~rxFull;
	wire rxPop     = rdDone & selData & ~rxEmpty;
	wire txPush    = wrDone & selData & ~txFull;
	wire txTaken   = linkEdge & hostTxValid_q & txReadyS;
	wire txLoad    = linkEdge & (txTaken | ~hostTxValid_q) & (txCount_q != 7'h00);
	wire hostTouch = rxTake | txTaken;

	// fill counts; data writes never reach the receive side
	assign rxCount_d = rxCount_q + {6'h00, rxPush} - {6'h00, rxPop};
	assign txCount_d = txCount_q + {6'h00, txPush} - {6'h00, txLoad};

	//////////////////////////////////////////////////////////////////////////
	// interrupt conditions
	wire rxOver = (rxCount_q > hdcu_pkg::IRQ_LEVEL);
	wire txFree7;
	wire [6:0] txFree = hdcu_pkg::DEPTH_CNT - txCount_q;
	assign txFree7 = (txFree > hdcu_pkg::IRQ_LEVEL);
	wire rxPendSet = ctrlEn_q[hdcu_pkg::RX_IE_BIT] & rxOver;
	wire txPendSet = ctrlEn_q[hdcu_pkg::TX_IE_BIT] & txFree7;
	wire [2:0] irqEvt = {hostTouch, txPendSet, rxPendSet};
	wire statClr = rdDone & selStat;
	assign irqStat_d = (statClr ? 3'h0 : irqStat_q) | irqEvt;     // set wins

	//////////////////////////////////////////////////////////////////////////
	// read data assembly
	wire [6:0]  rxShow   = rxEmpty ? 7'h00 : rxCount_q - 7'h01;
	wire [31:0] dataWord = {9'h000, rxShow, ~rxEmpty, 7'h00, rxMem[rxRd_q]};
	wire [31:0] ctrlWord = {9'h000, txFree, 5'h00, hostAcc_q, txPend_q, rxPend_q,
		6'h00, ctrlEn_q};
	wire [31:0] rdMux    = selData ? dataWord :
		selCtrl ? ctrlWord :
		selStat ? {29'h0000_0000, irqStat_q} :
		selMask ? {29'h0000_0000, irqMask_q} : 32'h0000_0000;

	//////////////////////////////////////////////////////////////////////////
	// apb handshake: one wait state, data and error registered
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else
		begin
			pready_q  <= accFirst;
			pslverr_q <= accFirst & ~mapped;
			if (accFirst & ~pwrite)
				prdata_q <= rdMux;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// receive queue
	always_ff @(posedge core_clk)
	begin
		if (rxPush)
			rxMem[rxWr_q] <= rxDataS;
		if (reset)
		begin
			rxWr_q    <= 6'h00;
			rxRd_q    <= 6'h00;
			rxCount_q <= 7'h00;
		end
		else
		begin
			rxWr_q    <= rxWr_q + {5'h00, rxPush};
			rxRd_q    <= rxRd_q + {5'h00, rxPop};
			rxCount_q <= rxCount_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// transmit queue and host-facing byte register
	always_ff @(posedge core_clk)
	begin
		if (txPush)
			txMem[txWr_q] <= pwdata[7:0];
		if (reset)
		begin
			txWr_q        <= 6'h00;
			txRd_q        <= 6'h00;
			txCount_q     <= 7'h00;
			hostTxValid_q <= 1'b0;
			hostTxData_q  <= 8'h00;
			hostRxReady_q <= 1'b0;
		end
		else
		begin
			txWr_q        <= txWr_q + {5'h00, txPush};
			txRd_q        <= txRd_q + {5'h00, txLoad};
			txCount_q     <= txCount_d;
			hostRxReady_q <= 1'b1;   // full queue drops, never stalls
			if (txLoad)
			begin
				hostTxValid_q <= 1'b1;
				hostTxData_q  <= txMem[txRd_q];
			end
			else if (txTaken)
				hostTxValid_q <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// control, pending and interrupt state
	wire ctrlWr = wrDone & selCtrl;
	wire dataRd = rdDone & selData;
	wire dataWr = wrDone & selData;
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			ctrlEn_q  <= hdcu_pkg::CTRL_RST;
			rxPend_q  <= 1'b0;
			txPend_q  <= 1'b0;
			hostAcc_q <= 1'b0;
			irqStat_q <= 3'h0;
			irqMask_q <= hdcu_pkg::IMASK_RST;
			irq_q     <= 1'b0;
		end
		else
		begin
			if (ctrlWr)
				ctrlEn_q <= pwdata[1:0];
			if (wrDone & selMask)
				irqMask_q <= pwdata[2:0];
			rxPend_q  <= rxPendSet | (rxPend_q & ~dataRd);
			txPend_q  <= txPendSet | (txPend_q & ~dataWr);
			hostAcc_q <= hostTouch |
				(hostAcc_q & ~(ctrlWr & pwdata[hdcu_pkg::HOSTACC_BIT]));
			irqStat_q <= irqStat_d;
			irq_q     <= |(irqStat_d & irqMask_q);
		end
	end

	// outputs straight from flops
	assign prdata      = prdata_q;
	assign pready      = pready_q;
	assign pslverr     = pslverr_q;
	assign hostRxReady = hostRxReady_q;
	assign hostTxValid = hostTxValid_q;
	assign hostTxData  = hostTxData_q;
	assign irq         = irq_q;

	//////////////////////////////////////////////////////////////////////////
	// checks
	sequence seqDataRead;
		accFirst & ~pwrite & selData;
	endsequence
	sequence seqCtrlRead;
		accFirst & ~pwrite & selCtrl;
	endsequence

	chk_rx_push_fill: assert property (@(posedge core_clk) disable iff (reset)
		(rxPush & ~rxPop) |=> (rxCount_q == $past(rxCount_q) + 7'h01))
		else $error("receive fill did not grow on push");
	chk_rx_full_drop: assert property (@(posedge core_clk) disable iff (reset)
		(rxTake & rxFull & ~rxPop) |=> (rxCount_q == hdcu_pkg::DEPTH_CNT) && $stable(rxWr_q))
		else $error("full receive queue changed on host byte");
	chk_rx_valid_bit: assert property (@(posedge core_clk) disable iff (reset)
		seqDataRead |=> prdata_q[hdcu_pkg::RVALID_BIT] == ($past(rxCount_q) != 7'h00))
		else $error("receive valid bit wrong");
	chk_rx_count_shown: assert property (@(posedge core_clk) disable iff (reset)
		seqDataRead ##0 !rxEmpty |=> prdata_q[31:16] == {9'h000, $past(rxCount_q) - 7'h01})
		else $error("read fill not reduced by one");
	chk_empty_read_still: assert property (@(posedge core_clk) disable iff (reset)
		(dataRd & rxEmpty) |=> $stable(rxRd_q))
		else $error("empty read moved receive pointer");
	chk_write_rx_quiet: assert property (@(posedge core_clk) disable iff (reset)
		(dataWr & ~rxPush) |=> $stable(rxCount_q) && $stable(rxRd_q))
		else $error("data write disturbed receive queue");
	chk_tx_free_field: assert property (@(posedge core_clk) disable iff (reset)
		seqCtrlRead |=> prdata_q[31:16] == {9'h000, hdcu_pkg::DEPTH_CNT - $past(txCount_q)})
		else $error("transmit free space wrong");
	chk_tx_full_drop: assert property (@(posedge core_clk) disable iff (reset)
		(dataWr & txFull) |=> $stable(txWr_q))
		else $error("write into full transmit queue stored");
	chk_host_acc_clear: assert property (@(posedge core_clk) disable iff (reset)
		(ctrlWr & pwdata[hdcu_pkg::HOSTACC_BIT] & ~hostTouch) |=> !hostAcc_q)
		else $error("host accessed flag not cleared");
	chk_host_acc_set: assert property (@(posedge core_clk) disable iff (reset)
		hostTouch |=> hostAcc_q)
		else $error("host accessed flag not set");
	chk_rx_pend_raise: assert property (@(posedge core_clk) disable iff (reset)
		rxPendSet |=> rxPend_q ##1 (rxPend_q || $past(dataRd)))
		else $error("receive pending not raised");
	chk_rx_pend_clear: assert property (@(posedge core_clk) disable iff (reset)
		(dataRd & ~rxPendSet) |=> !rxPend_q)
		else $error("receive pending not cleared by data read");
	chk_tx_pend_clear: assert property (@(posedge core_clk) disable iff (reset)
		(dataWr & ~txPendSet) |=> !txPend_q)
		else $error("transmit pending not cleared by data write");
	chk_tx_push_fill: assert property (@(posedge core_clk) disable iff (reset)
		(txPush & ~txLoad) |=> (txCount_q == $past(txCount_q) + 7'h01))
		else $error("transmit fill did not grow on write");
	chk_rx_pop_ptr: assert property (@(posedge core_clk) disable iff (reset)
		rxPop |=> (rxRd_q == $past(rxRd_q) + 6'h01))
		else $error("receive pointer did not advance on read");
	chk_tx_hold: assert property (@(posedge core_clk) disable iff (reset)
		(hostTxValid_q & ~linkEdge) |=> hostTxValid_q && $stable(hostTxData_q))
		else $error("transmit byte dropped without handshake");

endmodule // hdcu_char_link
`default_nettype wire

/* File: sim/hdcu_host_model.sv */
// host side of the character link: makes the link clock, sends and collects bytes
// assumes the link pins of the character link top, all timed from linkClk
`timescale 1ns/10ps
`default_nettype none
module hdcu_host_model
(
	// link pins
	output logic       linkClk,
	output logic       hostRxValid,
	output logic [7:0] hostRxData,
	input  wire logic  hostRxReady,
	input  wire logic  hostTxValid,
	input  wire logic [7:0] hostTxData,
	output logic       hostTxReady,
	// bench control
	input  wire logic  txStall
);
	logic [7:0] txSeen[$];

	////////////////////////////////////////////////////////////////////////////
	// link clock, phase unrelated to the core clock
	initial
	begin
		linkClk = 1'b0;
		hostRxValid = 1'b0;
		hostRxData = 8'h00;
		#13;
		forever #200 linkClk = ~linkClk;
	end

	// offer n bytes, each held until an edge with ready high
	task automatic burst(input int n, input logic [7:0] base);
		@(posedge linkClk);
		for (int i = 0; i < n; i++)
		begin
			hostRxValid <= 1'b1;
			hostRxData <= base + 8'(i);
			do @(posedge linkClk); while (hostRxReady !== 1'b1);
		end
		hostRxValid <= 1'b0;
		hostRxData <= ~hostRxData; // released line, no stale value
	endtask

	// collect bytes on edges where both sides agree
	always @(posedge linkClk)
	begin
		if (hostTxValid === 1'b1 && hostTxReady === 1'b1)
			txSeen.push_back(hostTxData);
		hostTxReady <= ~txStall;
	end
endmodule // hdcu_host_model
`default_nettype wire

/* File: sim/host_debug_char_uart_tb.sv */
// self-checking bench for the character link, APB tasks and a host model
// assumes the design package, the link top and the host model are compiled
`timescale 1ns/10ps
`default_nettype none
module host_debug_char_uart_tb;
	logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [31:0] paddr, pwdata, prdata, rdat;
	logic        linkClk, hostRxValid, hostRxReady, hostTxValid, hostTxReady;
	logic        irq, txStall;
	logic [7:0]  hostRxData, hostTxData;
	int          failures, total_checks, cycles, n;

	////////////////////////////////////////////////////////////////////////////
	// device and host
	hdcu_char_link u_dut (.core_clk(core_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .linkClk(linkClk),
		.hostRxValid(hostRxValid), .hostRxData(hostRxData), .hostRxReady(hostRxReady),
		.hostTxValid(hostTxValid), .hostTxData(hostTxData), .hostTxReady(hostTxReady),
		.irq(irq));
	hdcu_host_model u_host (.linkClk(linkClk), .hostRxValid(hostRxValid),
		.hostRxData(hostRxData), .hostRxReady(hostRxReady), .hostTxValid(hostTxValid),
		.hostTxData(hostTxData), .hostTxReady(hostTxReady), .txStall(txStall));

	////////////////////////////////////////////////////////////////////////////
	// compare, bus cycle and verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		// no cycle count assumed here: a hang ends at the run's watchdog
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			tally_and_finish;
		end
	end

	// main sequence
	initial
	begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		txStall = 1'b0;
		paddr = 32'h0000_0000;
		pwdata = 32'h0000_0000;
		repeat (4) @(posedge core_clk);
		reset <= 1'b0;
		apb(1'b0, hdcu_pkg::DATA_ADDR, 32'h0000_0000);
		chk(rdat & 32'hFFFF_8000, 32'h0000_0000);
		chk({31'h0000_0000, hostRxReady}, 32'h0000_0001);
		apb(1'b0, hdcu_pkg::CTRL_ADDR, 32'h0000_0000);
		chk(rdat & 32'hFFFF_0400, 32'h0040_0000);
		apb(1'b0, 32'hFF20_1010, 32'h0000_0000);
		chk(rdat, 32'h0000_0000);
		chk({31'h0000_0000, err}, 32'h0000_0001);
		// host overfills the receive queue, interrupts raised and masked
		u_host.burst(66, 8'h10);
		repeat (8) @(posedge core_clk);
		apb(1'b1, hdcu_pkg::CTRL_ADDR, 32'h0000_0003);
		apb(1'b1, hdcu_pkg::IMASK_ADDR, 32'h0000_0001);
		repeat (3) @(posedge core_clk);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		apb(1'b0, hdcu_pkg::CTRL_ADDR, 32'h0000_0000);
		chk(rdat, 32'h0040_0703);
		apb(1'b1, hdcu_pkg::IMASK_ADDR, 32'h0000_0000);
		repeat (3) @(posedge core_clk);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		apb(1'b1, hdcu_pkg::CTRL_ADDR, 32'h0000_0400);
		for (int j = 0; j < 2; j++)
		begin
			apb(1'b0, hdcu_pkg::ISTAT_ADDR, 32'h0000_0000);
			chk(rdat & 32'h0000_0007, j ? 32'h0000_0000 : 32'h0000_0007);
		end
		apb(1'b0, hdcu_pkg::CTRL_ADDR, 32'h0000_0000);
		chk(rdat & 32'h0000_0400, 32'h0000_0000);
		// a write leaves the full receive queue alone, then drain it
		apb(1'b1, hdcu_pkg::DATA_ADDR, 32'h0000_0055);
		for (int i = 0; i < 64; i++)
		begin
			apb(1'b0, hdcu_pkg::DATA_ADDR, 32'h0000_0000);
			chk({rdat[31:15], rdat[7:0]}, {16'(63 - i), 1'b1, 8'h10 + 8'(i)});
		end
		for (int j = 0; j < 2; j++)
		begin
			apb(1'b0, hdcu_pkg::DATA_ADDR, 32'h0000_0000);
			chk(rdat & 32'hFFFF_8000, 32'h0000_0000);
		end
		// pendings cleared by the drain and the write, host touched the link again
		apb(1'b0, hdcu_pkg::CTRL_ADDR, 32'h0000_0000);
		chk(rdat & 32'h0000_0703, 32'h0000_0400);
		chk({24'h00_0000, u_host.txSeen.pop_front()}, 32'h0000_0055);
		// one more host byte after the empty reads lands at the read pointer
		u_host.burst(1, 8'hA5);
		repeat (8) @(posedge core_clk);
		apb(1'b0, hdcu_pkg::DATA_ADDR, 32'h0000_0000);
		chk({rdat[31:15], rdat[7:0]}, {16'h0000, 1'b1, 8'hA5});
		// transmit queue overflow while the host stalls
		txStall <= 1'b1;
		repeat (24) @(posedge core_clk);
		for (int i = 0; i < 70; i++)
			apb(1'b1, hdcu_pkg::DATA_ADDR, {24'h00_0000, 8'(i)});
		apb(1'b0, hdcu_pkg::CTRL_ADDR, 32'h0000_0000);
		chk(rdat & 32'hFFFF_0000, 32'h0000_0000);
		txStall <= 1'b0;
		repeat (700) @(posedge core_clk);
		n = u_host.txSeen.size();
		// a full queue plus the byte already offered on the link
		chk(32'(n), 32'(hdcu_pkg::DEPTH + 1));
		for (int i = 0; i < n; i++)
			chk({24'h00_0000, u_host.txSeen[i]}, 32'(i));
		apb(1'b0, hdcu_pkg::CTRL_ADDR, 32'h0000_0000);
		chk(rdat & 32'hFFFF_0000, 32'h0040_0000);
		tally_and_finish;
	end
endmodule // host_debug_char_uart_tb
`default_nettype wire
